/* hdl/ecx_pkg.sv */
package ecx_pkg;
  // Operating modes held in the top bits of the extended control register.
  typedef enum logic [2:0] {
    ECX_MODE_STD = 3'b000,
    ECX_MODE_BIDIR = 3'b001,
    ECX_MODE_PFIFO = 3'b010,
    ECX_MODE_ECP = 3'b011,
    ECX_MODE_EPP = 3'b100,
    ECX_MODE_RSVD = 3'b101,
    ECX_MODE_TEST = 3'b110,
    ECX_MODE_CFG = 3'b111
  } ecx_mode_type;

  // Host-side register selectors on the register port.
  localparam logic [2:0] ECX_SEL_INDEX = 3'h0;
  localparam logic [2:0] ECX_SEL_DATA = 3'h1;
  localparam logic [2:0] ECX_SEL_AUX = 3'h2;
  localparam logic [2:0] ECX_SEL_PCTL = 3'h3;
  localparam logic [2:0] ECX_SEL_PDATA = 3'h4;

  // Second-level indices behind the extended index register.
  localparam logic [2:0] ECX_IDX_CTL0 = 3'h0;
  localparam logic [2:0] ECX_IDX_CTL2 = 3'h2;
  localparam logic [2:0] ECX_IDX_CTL4 = 3'h4;
  localparam logic [2:0] ECX_IDX_CFG0 = 3'h5;

  // Reset values.
  localparam logic [7:0] ECX_CTL0_RST = 8'h00;
  localparam logic [7:0] ECX_CTL2_RST = 8'h00;
  localparam logic [7:0] ECX_CTL4_RST = 8'h07;
  localparam logic [7:0] ECX_CFG0_RST = 8'h00;
  localparam logic [7:0] ECX_AUX_RST = 8'h00;

  // Field positions.
  localparam int ECX_C0_TOMASK = 0;
  localparam int ECX_C0_FREEZE = 4;
  localparam int ECX_C0_LIVE = 5;
  localparam int ECX_C2_ZWS17 = 3;
  localparam int ECX_C2_EPP19 = 4;
  localparam int ECX_C2_CHANEN = 6;
  localparam int ECX_C2_SPPCOMP = 7;
  localparam int ECX_CF_PEPULL = 2;
  localparam int ECX_CF_DEMAND = 6;
  localparam int ECX_CF_CNFGA3 = 7;
  localparam int ECX_PC_IRQEN = 4;
  localparam int ECX_PC_DIR = 5;

  // Timing: the slow reference clock and the demand-DMA figures.
  localparam int ECX_CLK_MHZ = 250;
  localparam int ECX_REF_MHZ = 24;
  localparam int ECX_FLUSH_COUNTS = 256;
  localparam int ECX_DEMAND_THRESH = 4;
  localparam int ECX_BURST_LEN = 4;
  localparam int ECX_REST_BASE = 8;
  localparam int ECX_REST_STEP = 32;
endpackage : ecx_pkg

/* hdl/ecx_ext_ctl.sv */
`timescale 1ns/10ps
module ecx_ext_ctl
  import ecx_pkg::*;
#(
  parameter int FIFO_AW = 5,
  parameter int BUF_W = 9
)(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Port state from the surrounding port logic.
  input wire logic [2:0] ecr_mode_i,
  input wire logic [7:0] pctl_q_i,
  input wire logic [7:0] pdata_q_i,
  input wire logic fifo_tag_bottom_i,
  input wire logic [FIFO_AW:0] fifo_free_i,
  input wire logic [FIFO_AW:0] fifo_count_i,
  input wire logic dma_xfer_i,
  input wire logic ecp_irq_i,
  input wire logic epp_timeout_i,
  input wire logic status_rd_i,
  // Pins, asynchronous to clk_i.
  input wire logic [3:0] ctl_pins_i,
  input wire logic [7:0] data_pins_i,
  input wire logic ack_n_i,
  // Incoming peripheral bytes: tag is BUSY, high for data.
  input wire logic in_valid_i,
  input wire logic in_tag_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o,
  // Bytes toward the FIFO.
  output logic fifo_valid_o,
  output logic fifo_tag_o,
  output logic [7:0] fifo_data_o,
  input wire logic fifo_ready_i,
  // Control outputs.
  output logic dma_req_o,
  output logic irq_o,
  output logic irq_oe_o,
  output logic dsr_irq_status_o,
  output logic zws_o,
  output logic epp19_o,
  output logic freeze_o,
  output logic freeze_reinit_o,
  output logic fifo_hold_empty_o,
  output logic hw_xfer_en_o,
  output logic dma_fill_en_o,
  output logic dir_eff_o,
  output logic pd_oe_o,
  output logic pe_pullup_o,
  output logic [7:0] config_b_readback_o,
  output logic config_a_bit3_o
);

  typedef enum logic [1:0] {
    ECX_DQ_IDLE = 2'b00,
    ECX_DQ_ACT = 2'b01,
    ECX_DQ_REST = 2'b10
  } ecx_dq_type;

  localparam logic [7:0] REF_INC = 8'(ECX_REF_MHZ);
  localparam logic [8:0] REF_WRAP = 9'(ECX_CLK_MHZ);

  // True when the index names an implemented register.
  function automatic logic idx_ok(input logic [2:0] idx);
    idx_ok = (idx == ECX_IDX_CTL0) || (idx == ECX_IDX_CTL2) ||
             (idx == ECX_IDX_CTL4) || (idx == ECX_IDX_CFG0);
  endfunction : idx_ok

  // True for the modes that have a compatible variant.
  function automatic logic compat_mode(input logic [2:0] m);
    compat_mode = (m == ECX_MODE_STD) || (m == ECX_MODE_BIDIR) || (m == ECX_MODE_EPP);
  endfunction : compat_mode

  logic [2:0] idx_q;
  logic [7:0] ctl0_q, ctl2_q, ctl4_q, cfg0_q;
  logic [2:0] mode_q;
  logic mode_chg;
  logic [2:0] mode;
  logic dir;
  logic compat;
  logic [3:0] cp_s1_q, cp_s2_q, cp_s3_q, cp_q;
  logic [7:0] dp_s1_q, dp_s2_q, dp_s3_q, dp_q;
  logic [2:0] ack_s_q;
  logic ack_q;

  assign mode = ecr_mode_i;
  assign dir = (mode == ECX_MODE_STD || mode == ECX_MODE_PFIFO) ? 1'b0 : pctl_q_i[ECX_PC_DIR];
  assign compat = ctl2_q[ECX_C2_SPPCOMP] && compat_mode(mode);
  assign mode_chg = (mode != mode_q);

  // Pin synchronisers; a level counts only once stages two and three agree.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cp_s1_q <= 4'h0;
      cp_s2_q <= 4'h0;
      cp_s3_q <= 4'h0;
      cp_q <= 4'h0;
      dp_s1_q <= 8'h00;
      dp_s2_q <= 8'h00;
      dp_s3_q <= 8'h00;
      dp_q <= 8'h00;
      ack_s_q <= 3'h7;
      ack_q <= 1'b1;
    end
    else
    begin
      cp_s1_q <= ctl_pins_i;
      cp_s2_q <= cp_s1_q;
      cp_s3_q <= cp_s2_q;
      dp_s1_q <= data_pins_i;
      dp_s2_q <= dp_s1_q;
      dp_s3_q <= dp_s2_q;
      ack_s_q <= {ack_s_q[1:0], ack_n_i};
      for (int i = 0; i < 4; i++)
        if (cp_s2_q[i] == cp_s3_q[i]) cp_q[i] <= cp_s3_q[i];
      for (int i = 0; i < 8; i++)
        if (dp_s2_q[i] == dp_s3_q[i]) dp_q[i] <= dp_s3_q[i];
      if (ack_s_q[1] == ack_s_q[2]) ack_q <= ack_s_q[2];
    end
  end

  // Index and extended registers; unlisted indices swallow the write.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idx_q <= 3'h0;
      ctl0_q <= ECX_CTL0_RST;
      ctl2_q <= ECX_CTL2_RST;
      ctl4_q <= ECX_CTL4_RST;
      cfg0_q <= ECX_CFG0_RST;
      mode_q <= ECX_MODE_STD;
    end
    else
    begin
      mode_q <= mode;
      if (reg_wr_i && reg_sel_i == ECX_SEL_INDEX) idx_q <= reg_wdata_i[2:0];
      if (reg_wr_i && reg_sel_i == ECX_SEL_DATA && idx_ok(idx_q))
      begin
        case (idx_q)
          ECX_IDX_CTL0: ctl0_q <= reg_wdata_i;
          ECX_IDX_CTL2: ctl2_q <= reg_wdata_i;
          ECX_IDX_CTL4: ctl4_q <= reg_wdata_i;
          default: cfg0_q <= reg_wdata_i;
        endcase
      end
    end
  end

  // Read data, one cycle after the read strobe.
  logic [7:0] rd_d;
  always_comb
  begin
    rd_d = 8'h00;
    case (reg_sel_i)
      ECX_SEL_INDEX: rd_d = {5'h00, idx_q};
      ECX_SEL_DATA:
        case (idx_q)
          ECX_IDX_CTL0: rd_d = ctl0_q;
          ECX_IDX_CTL2: rd_d = ctl2_q;
          ECX_IDX_CTL4: rd_d = ctl4_q;
          ECX_IDX_CFG0: rd_d = cfg0_q;
          default: rd_d = 8'h00;
        endcase
      // The tag is undefined elsewhere; zero keeps reads deterministic.
      ECX_SEL_AUX: rd_d = {(mode == ECX_MODE_ECP && dir) ? fifo_tag_bottom_i : 1'b0,
                           ECX_AUX_RST[6:0]};
      ECX_SEL_PCTL:
      begin
        rd_d = pctl_q_i;
        if (ctl0_q[ECX_C0_LIVE] || compat) rd_d[3:0] = cp_q;
        if (compat && mode != ECX_MODE_EPP) rd_d[ECX_PC_DIR] = 1'b1;
      end
      ECX_SEL_PDATA: rd_d = (compat && !dir) ? pdata_q_i : dp_q;
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i) reg_rdata_o <= 8'h00;
    else if (reg_rd_i) reg_rdata_o <= rd_d;
  end

  // Interrupt path; an ACK edge in the clearing cycle still sets the flag.
  logic ack_prev_q;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_prev_q <= 1'b1;
      dsr_irq_status_o <= 1'b0;
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end
    else
    begin
      ack_prev_q <= ack_q;
      if (compat && mode == ECX_MODE_BIDIR && ack_q && !ack_prev_q)
        dsr_irq_status_o <= 1'b1;
      else if (status_rd_i || !(compat && mode == ECX_MODE_BIDIR))
        dsr_irq_status_o <= 1'b0;
      irq_o <= ecp_irq_i || (epp_timeout_i && ctl0_q[ECX_C0_TOMASK]) ||
               (compat && mode == ECX_MODE_BIDIR && dsr_irq_status_o);
      irq_oe_o <= !(compat && !pctl_q_i[ECX_PC_IRQEN]);
    end
  end

  // Static controls derived from mode and registers.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zws_o <= 1'b0;
      epp19_o <= 1'b0;
      freeze_o <= 1'b0;
      freeze_reinit_o <= 1'b0;
      fifo_hold_empty_o <= 1'b1;
      hw_xfer_en_o <= 1'b0;
      dma_fill_en_o <= 1'b0;
      dir_eff_o <= 1'b0;
      pd_oe_o <= 1'b1;
      pe_pullup_o <= 1'b0;
      config_b_readback_o <= 8'h00;
      config_a_bit3_o <= 1'b0;
    end
    else
    begin
      epp19_o <= ctl2_q[ECX_C2_EPP19];
      if (mode == ECX_MODE_EPP)
        zws_o <= !ctl2_q[ECX_C2_EPP19] && ctl2_q[ECX_C2_ZWS17];
      else
        zws_o <= !compat;
      freeze_o <= (mode == ECX_MODE_ECP) && ctl0_q[ECX_C0_FREEZE];
      freeze_reinit_o <= freeze_o && (mode == ECX_MODE_ECP) && !ctl0_q[ECX_C0_FREEZE];
      fifo_hold_empty_o <= (mode == ECX_MODE_STD) || (mode == ECX_MODE_BIDIR);
      hw_xfer_en_o <= (mode == ECX_MODE_PFIFO) || (mode == ECX_MODE_ECP);
      dma_fill_en_o <= (mode == ECX_MODE_PFIFO) || (mode == ECX_MODE_ECP) ||
                       (mode == ECX_MODE_TEST);
      dir_eff_o <= dir;
      pd_oe_o <= !dir;
      pe_pullup_o <= cfg0_q[ECX_CF_PEPULL];
      // Mirror only; real routing lives elsewhere.
      config_b_readback_o <= {2'b00, cfg0_q[5:3], 1'b0, cfg0_q[1:0]};
      config_a_bit3_o <= cfg0_q[ECX_CF_CNFGA3];
    end
  end

  // Two-entry buffer toward the FIFO; head entry drives the outputs directly.
  logic v1_q;
  logic [BUF_W-1:0] d1_q;
  logic keep, push, pop, buf_flush;
  assign keep = in_tag_i || (ctl2_q[ECX_C2_CHANEN] && mode == ECX_MODE_ECP && dir &&
                in_data_i[7]);
  assign push = in_valid_i && in_ready_o && keep;
  assign pop = fifo_valid_o && fifo_ready_i;
  // Run-length counts are consumed here but not stored; expansion is outside.
  assign buf_flush = mode_chg || fifo_hold_empty_o;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fifo_valid_o <= 1'b0;
      fifo_tag_o <= 1'b0;
      fifo_data_o <= 8'h00;
      v1_q <= 1'b0;
      d1_q <= '0;
      in_ready_o <= 1'b0;
    end
    else if (buf_flush)
    begin
      fifo_valid_o <= 1'b0;
      v1_q <= 1'b0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (pop)
      begin
        fifo_valid_o <= v1_q || push;
        if (v1_q) {fifo_tag_o, fifo_data_o} <= d1_q;
        else if (push) {fifo_tag_o, fifo_data_o} <= {in_tag_i, in_data_i};
        v1_q <= v1_q && push;
        if (v1_q && push) d1_q <= {in_tag_i, in_data_i};
        in_ready_o <= 1'b1;
      end
      else if (push)
      begin
        if (!fifo_valid_o)
        begin
          fifo_valid_o <= 1'b1;
          {fifo_tag_o, fifo_data_o} <= {in_tag_i, in_data_i};
        end
        else
        begin
          v1_q <= 1'b1;
          d1_q <= {in_tag_i, in_data_i};
          in_ready_o <= 1'b0;
        end
      end
    end
  end

  // Reference tick: fractional divider gives one pulse per 24 MHz period.
  logic [7:0] acc_q;
  logic ref_tick_q;
  logic [8:0] acc_sum;
  assign acc_sum = {1'b0, acc_q} + {1'b0, REF_INC};
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc_q <= 8'h00;
      ref_tick_q <= 1'b0;
    end
    else
    begin
      ref_tick_q <= (acc_sum >= REF_WRAP);
      acc_q <= (acc_sum >= REF_WRAP) ? 8'(acc_sum - REF_WRAP) : acc_sum[7:0];
    end
  end

  // Demand DMA.
  ecx_dq_type dq_q;
  logic [7:0] flush_q;
  logic flush_run_q, flush_exp;
  logic [5:0] act_q, act_lim;
  logic [1:0] burst_q;
  logic [7:0] rest_q;
  logic demand, thresh, able;
  assign demand = cfg0_q[ECX_CF_DEMAND] && dma_fill_en_o;
  assign thresh = dir ? (fifo_count_i >= (FIFO_AW+1)'(ECX_DEMAND_THRESH))
                      : (fifo_free_i >= (FIFO_AW+1)'(ECX_DEMAND_THRESH));
  assign able = !(dir && fifo_count_i == '0);
  // Widened before the add so that a field of 7 gives 32 and does not wrap to 0.
  assign act_lim = (ctl4_q[2:0] == 3'h0) ? 6'h01 : ({1'b0, ctl4_q[2:0], 2'b00} + 6'h04);
  assign flush_exp = flush_run_q && ref_tick_q && flush_q == 8'(ECX_FLUSH_COUNTS - 1);

  // Flush counter: armed by a backward store while no request is up.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flush_q <= 8'h00;
      flush_run_q <= 1'b0;
    end
    else if (!demand || !dir || dma_req_o || mode_chg || flush_exp)
    begin
      flush_q <= 8'h00;
      flush_run_q <= 1'b0;
    end
    else
    begin
      if (pop) flush_run_q <= 1'b1;
      if (flush_run_q && ref_tick_q) flush_q <= flush_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dq_q <= ECX_DQ_IDLE;
      dma_req_o <= 1'b0;
      act_q <= 6'h00;
      burst_q <= 2'h0;
      rest_q <= 8'h00;
    end
    else if (mode_chg || !demand)
    begin
      dq_q <= ECX_DQ_IDLE;
      dma_req_o <= 1'b0;
      act_q <= 6'h00;
      burst_q <= 2'h0;
    end
    else
    begin
      case (dq_q)
        ECX_DQ_IDLE:
          if (thresh || flush_exp)
          begin
            dq_q <= ECX_DQ_ACT;
            dma_req_o <= 1'b1;
            burst_q <= 2'h0;
          end
        ECX_DQ_ACT:
          if (dma_xfer_i)
          begin
            act_q <= act_q + 6'h01;
            burst_q <= burst_q + 2'h1;
            if (act_q + 6'h01 >= act_lim)
            begin
              dq_q <= ECX_DQ_REST;
              dma_req_o <= 1'b0;
              rest_q <= 8'(ECX_REST_BASE) + {ctl4_q[6:4], 5'h00};
            end
            else if (burst_q == 2'(ECX_BURST_LEN - 1) && !thresh)
            begin
              dq_q <= ECX_DQ_IDLE;
              dma_req_o <= 1'b0;
              act_q <= 6'h00;
            end
          end
          else if (!able)
          begin
            dq_q <= ECX_DQ_IDLE;
            dma_req_o <= 1'b0;
            act_q <= 6'h00;
          end
        // The first tick may come at once, so one extra tick keeps whole periods.
        ECX_DQ_REST:
          if (rest_q == 8'h00 && ref_tick_q)
          begin
            dq_q <= ECX_DQ_IDLE;
            act_q <= 6'h00;
          end
          else if (ref_tick_q) rest_q <= rest_q - 8'h01;
        default:
        begin
          dq_q <= ECX_DQ_IDLE;
          dma_req_o <= 1'b0;
        end
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  bad_index_write_a: assert property (reg_wr_i && reg_sel_i == ECX_SEL_DATA && !idx_ok(idx_q)
    |=> $stable(ctl0_q) && $stable(ctl2_q) && $stable(ctl4_q) && $stable(cfg0_q))
    else $error("write through an unlisted index changed a register");
  data_port_rd_a: assert property (reg_rd_i && reg_sel_i == ECX_SEL_DATA &&
    idx_q == ECX_IDX_CTL4 ##1 !$changed(ctl4_q) |-> reg_rdata_o == ctl4_q)
    else $error("data port read did not return the indexed register");
  fair_cap_a: assert property (dma_req_o |-> act_q < act_lim)
    else $error("request stayed up beyond the fairness cap");
  rest_hold_a: assert property (dq_q == ECX_DQ_REST && rest_q != 8'h00 |=> !dma_req_o)
    else $error("request came back during the inactive time");
  flush_clear_a: assert property (dma_req_o |=> flush_q == 8'h00 && !flush_run_q)
    else $error("flush counter ran while the request was up");
  mode_reset_a: assert property (mode_chg |=> !dma_req_o && dq_q == ECX_DQ_IDLE)
    else $error("mode change left demand DMA active");
  irq_float_a: assert property (compat && !pctl_q_i[ECX_PC_IRQEN] |=> !irq_oe_o)
    else $error("interrupt line driven while it should float");
  zws_epp19_a: assert property (mode == ECX_MODE_EPP && ctl2_q[ECX_C2_EPP19] ##1
    mode == ECX_MODE_EPP |-> !zws_o)
    else $error("zero-wait-state given on an EPP 1.9 access");
  fifo_empty_a: assert property (mode == ECX_MODE_STD |=> fifo_hold_empty_o && !dir_eff_o)
    else $error("standard mode did not hold the FIFO empty and forward");
  buf_full_a: assert property (fifo_valid_o && v1_q |-> !in_ready_o)
    else $error("buffer accepted a byte while full");

  burst_c: cover property (dma_req_o ##1 dma_xfer_i [*4] ##1 dma_req_o);
  fair_rest_c: cover property (dq_q == ECX_DQ_ACT ##1 dq_q == ECX_DQ_REST);
  flush_c: cover property (flush_exp ##1 dma_req_o);
  buf_stall_c: cover property (v1_q && !fifo_ready_i);

endmodule : ecx_ext_ctl

/* verification/ecx_far_model.sv */
`timescale 1ns/10ps
// Far side: the host DMA controller that answers requests, and the FIFO that takes bytes.
module ecx_far_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Demand request and transfer pulse.
  input wire logic req_i,
  output logic xfer_o,
  // FIFO write side.
  input wire logic valid_i,
  input wire logic tag_i,
  input wire logic [7:0] data_i,
  input wire logic stall_i,
  output logic ready_o
);
  logic [8:0] got[$];
  // One transfer every other cycle while the request stands; no faster than a real controller.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      xfer_o <= 1'b0;
    else
      xfer_o <= req_i & ~xfer_o;
  end
  // The FIFO stalls on command, so the buffer in front of it has to hold words.
  assign ready_o = ~stall_i;
  // Every word taken is kept for the bench to compare in order.
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
      got.push_back({tag_i, data_i});
  end
endmodule : ecx_far_model

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import ecx_pkg::*;
  logic clk_i, rstn_i, reg_rd_i, reg_wr_i, fifo_tag_bottom_i, dma_xfer_i, ecp_irq_i, stall;
  logic epp_timeout_i, status_rd_i, ack_n_i, in_valid_i, in_tag_i, fifo_ready_i, fifo_tag_o;
  logic [2:0] reg_sel_i, ecr_mode_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, pctl_q_i, pdata_q_i, data_pins_i, in_data_i, v;
  logic [7:0] fifo_data_o, config_b_readback_o;
  logic [5:0] fifo_free_i, fifo_count_i;
  logic [3:0] ctl_pins_i;
  logic in_ready_o, fifo_valid_o, dma_req_o, irq_o, irq_oe_o, dsr_irq_status_o, zws_o, epp19_o;
  logic freeze_o, fifo_hold_empty_o, hw_xfer_en_o, dma_fill_en_o, dir_eff_o, pd_oe_o;
  logic pe_pullup_o, config_a_bit3_o;
  int miscompares, samples_checked, n, lc;
  logic [2:0] ix[4] = '{ECX_IDX_CTL0, ECX_IDX_CTL2, ECX_IDX_CTL4, ECX_IDX_CFG0};
  logic [7:0] rv[4] = '{ECX_CTL0_RST, ECX_CTL2_RST, ECX_CTL4_RST, ECX_CFG0_RST};
  logic [7:0] wv[4] = '{8'h11, 8'hD8, 8'h77, 8'hFF};

  ecx_ext_ctl ecx_ext_ctl_inst (
    .clk_i, .rstn_i, .reg_sel_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .ecr_mode_i, .pctl_q_i, .pdata_q_i, .fifo_tag_bottom_i, .fifo_free_i, .fifo_count_i,
    .dma_xfer_i, .ecp_irq_i, .epp_timeout_i, .status_rd_i, .ctl_pins_i, .data_pins_i,
    .ack_n_i, .in_valid_i, .in_tag_i, .in_data_i, .in_ready_o, .fifo_valid_o, .fifo_tag_o,
    .fifo_data_o, .fifo_ready_i, .dma_req_o, .irq_o, .irq_oe_o, .dsr_irq_status_o, .zws_o,
    .epp19_o, .freeze_o, .freeze_reinit_o(), .fifo_hold_empty_o, .hw_xfer_en_o,
    .dma_fill_en_o, .dir_eff_o, .pd_oe_o, .pe_pullup_o, .config_b_readback_o,
    .config_a_bit3_o
  );
  ecx_far_model ecx_far_model_inst (
    .clk_i, .rstn_i, .req_i(dma_req_o), .xfer_o(dma_xfer_i), .valid_i(fifo_valid_o),
    .tag_i(fifo_tag_o), .data_i(fifo_data_o), .stall_i(stall), .ready_o(fifo_ready_i)
  );

  // Free-running 250 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic w(input int k);
    repeat (k) @(posedge clk_i);
  endtask : w

  // Strobes rise one edge and drop the next, so back-to-back calls never overlap.
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_i);
    reg_sel_i <= s;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] s);
    @(posedge clk_i);
    reg_sel_i <= s;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic xw(input logic [2:0] i, input logic [7:0] d);
    wr(ECX_SEL_INDEX, {5'h00, i});
    wr(ECX_SEL_DATA, d);
  endtask : xw

  task automatic xr(input logic [2:0] i);
    wr(ECX_SEL_INDEX, {5'h00, i});
    rd(ECX_SEL_DATA);
  endtask : xr

  // The byte is held until an edge sees the buffer ready, giving up after 40 more edges.
  task automatic put(input logic t, input logic [7:0] d);
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    in_tag_i <= t;
    in_data_i <= d;
    @(posedge clk_i);
    for (n = 0; n < 40 && in_ready_o !== 1'b1; n++) @(posedge clk_i);
    in_valid_i <= 1'b0;
  endtask : put

  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Cuts a hang short; the tests need about 20 us.
  initial
  begin
    #80000;
    miscompares++;
    summarize();
  end

  initial
  begin
    {rstn_i, reg_rd_i, reg_wr_i, reg_sel_i, reg_wdata_i, fifo_tag_bottom_i} = '0;
    {ecp_irq_i, epp_timeout_i, status_rd_i, in_valid_i, in_tag_i, in_data_i} = '0;
    {fifo_free_i, fifo_count_i} = '0;
    ecr_mode_i = ECX_MODE_STD;
    pctl_q_i = 8'h20;
    pdata_q_i = 8'h5A;
    data_pins_i = 8'hC3;
    ctl_pins_i = 4'hA;
    ack_n_i = 1'b1;
    stall = 1'b1;
    w(5);
    rstn_i <= 1'b1;
    // Reset values, then write and read back through the index.
    for (int i = 0; i < 4; i++)
    begin
      xr(ix[i]);
      chk(v, rv[i]);
      xw(ix[i], wv[i]);
      xr(ix[i]);
      chk(v, wv[i]);
    end
    xw(3'h3, 8'hAA);
    xr(3'h3);
    chk(v, 8'h00);
    chk({pe_pullup_o, config_a_bit3_o, epp19_o}, 3'b111);
    chk(config_b_readback_o, 8'h3B);
    // Every mode: freeze only in 011, FIFO held in 000/001, transfers and DMA by mode.
    for (int m = 0; m < 8; m++)
    begin
      ecr_mode_i <= m[2:0];
      w(4);
      chk({freeze_o, fifo_hold_empty_o, hw_xfer_en_o, dma_fill_en_o},
        {m == 3, m < 2, m == 2 || m == 3, m == 2 || m == 3 || m == 6});
      if (m < 2)
        chk({dir_eff_o, pd_oe_o}, {m == 1, m == 0});
    end
    // Zero-wait-state per EPP version and bit 3, then always in mode 010.
    ecr_mode_i <= ECX_MODE_EPP;
    xw(ECX_IDX_CTL2, 8'hD8);
    w(3);
    chk(zws_o, 1'b0);
    xw(ECX_IDX_CTL2, 8'hC8);
    w(3);
    chk({zws_o, epp19_o}, 2'b10);
    xw(ECX_IDX_CTL2, 8'hC0);
    w(3);
    chk(zws_o, 1'b0);
    ecr_mode_i <= ECX_MODE_PFIFO;
    w(3);
    chk(zws_o, 1'b1);
    // Live readback of control pins against stored contents.
    xw(ECX_IDX_CTL0, 8'h31);
    rd(ECX_SEL_PCTL);
    chk(v[3:0], 4'hA);
    xw(ECX_IDX_CTL0, 8'h11);
    rd(ECX_SEL_PCTL);
    chk(v, 8'h20);
    // Compatible mode 000: pin bits, bit 5 high, latched data, floated interrupt.
    ecr_mode_i <= ECX_MODE_STD;
    pctl_q_i <= 8'h00;
    rd(ECX_SEL_PCTL);
    chk({v[5], v[3:0]}, 5'h1A);
    rd(ECX_SEL_PDATA);
    chk(v, 8'h5A);
    chk(irq_oe_o, 1'b0);
    // Mode 001: trailing ACK edge raises a level interrupt, a status read clears it.
    ecr_mode_i <= ECX_MODE_BIDIR;
    pctl_q_i <= 8'h10;
    ack_n_i <= 1'b0;
    w(6);
    ack_n_i <= 1'b1;
    w(10);
    chk({dsr_irq_status_o, irq_o, irq_oe_o}, 3'b111);
    status_rd_i <= 1'b1;
    w(1);
    status_rd_i <= 1'b0;
    w(4);
    chk({dsr_irq_status_o, irq_o}, 2'b00);
    // Mode 011 backward: tag bit readback and command capture through a stalled buffer.
    ecr_mode_i <= ECX_MODE_ECP;
    pctl_q_i <= 8'h20;
    fifo_tag_bottom_i <= 1'b1;
    rd(ECX_SEL_AUX);
    chk(v[7], 1'b1);
    put(1'b0, 8'h85);
    put(1'b0, 8'h05);
    put(1'b1, 8'h3C);
    w(3);
    chk(in_ready_o, 1'b0);
    stall <= 1'b0;
    put(1'b1, 8'h11);
    w(6);
    chk(9'(ecx_far_model_inst.got.size()), 9'd3);
    chk(ecx_far_model_inst.got[0], 9'h085);
    chk(ecx_far_model_inst.got[1], 9'h13C);
    chk(ecx_far_model_inst.got[2], 9'h111);
    // Time-out interrupt passes only while the mask bit is set.
    epp_timeout_i <= 1'b1;
    w(3);
    chk(irq_o, 1'b1);
    xw(ECX_IDX_CTL0, 8'h10);
    w(3);
    chk(irq_o, 1'b0);
    epp_timeout_i <= 1'b0;
    // Demand DMA: no request below threshold, fairness cap, then the rest period.
    xw(ECX_IDX_CFG0, 8'h40);
    pctl_q_i <= 8'h00;
    for (int c = 0; c < 2; c++)
    begin
      ecr_mode_i <= ECX_MODE_STD;
      fifo_free_i <= 6'd0;
      xw(ECX_IDX_CTL4, c ? 8'h10 : 8'h07);
      w(700);
      ecr_mode_i <= ECX_MODE_PFIFO;
      fifo_free_i <= 6'd3;
      w(20);
      chk(dma_req_o, 1'b0);
      fifo_free_i <= 6'd8;
      for (n = 0; n < 20 && dma_req_o !== 1'b1; n++) @(posedge clk_i);
      chk(dma_req_o, 1'b1);
      lc = 0;
      for (n = 0; n < 200 && dma_req_o === 1'b1; n++)
      begin
        @(posedge clk_i);
        lc += dma_xfer_i;
      end
      chk(9'(lc), c ? 9'd1 : 9'd32);
      for (lc = 0; lc < 800 && dma_req_o !== 1'b1; lc++) @(posedge clk_i);
      chk(lc >= (c ? 410 : 80) && lc < 800, 1'b1);
    end
    // Flush time-out: one backward byte below threshold raises the request after 256 ticks.
    pctl_q_i <= 8'h20;
    fifo_count_i <= 6'd1;
    ecr_mode_i <= ECX_MODE_ECP;
    w(3);
    put(1'b1, 8'h42);
    w(2640);
    chk(dma_req_o, 1'b0);
    for (n = 0; n < 100 && dma_req_o !== 1'b1; n++) @(posedge clk_i);
    chk(dma_req_o, 1'b1);
    summarize();
  end
endmodule : testbench
